/* src/uaw_cfg.svh */
`ifndef UAW_CFG_SVH
`define UAW_CFG_SVH
// register offsets
`define UAW_OFS_CTRL 8'h00
`define UAW_OFS_STAT 8'h04
`define UAW_OFS_DIVL 8'h08
`define UAW_OFS_DIVH 8'h0c
`define UAW_OFS_RXDATA 8'h10
// control fields
`define UAW_CTRL_ABD 0
`define UAW_CTRL_WAKE 1
`define UAW_CTRL_SYNC 2
`define UAW_CTRL_SLEEP 3
// status fields
`define UAW_STAT_RXFLAG 0
`define UAW_STAT_OVF 1
`define UAW_STAT_IDLE 2
// reset values
`define UAW_RST_CTRL 4'h0
`define UAW_RST_DIV 16'h0000
`define UAW_RST_DATA 8'h00
// measurement figures
`define UAW_CNT_WIDTH 16
`define UAW_LAST_EDGE 3'h5
`endif

/* src/uaw_pkg.sv */
package uaw_pkg;
  `include "uaw_cfg.svh"

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } uaw_bus_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic done;
    logic busy;
  } uaw_char_in_t;

  typedef enum logic [1:0] {
    ABD_IDLE = 2'b00,
    ABD_WAIT_FIRST = 2'b01,
    ABD_MEASURE = 2'b10
  } uaw_abd_state_t;
endpackage

/* src/uaw_autobaud_wake.sv */
// Summary of operation
// RQ1: overflow flag sets if interval counter wraps before fifth rising receive edge.
// RQ2: measurement counter is 16 bits, matching the divisor high and low pair.
// RQ3: counter keeps running after overflow until the fifth rising edge.
// RQ4: fifth rising edge sets receive flag and clears auto baud enable.
// RQ5: reading the receive data register clears the receive flag.
// RQ6: software clears the overflow flag by writing it directly.
// RQ7: abort clears enable first, then overflow; overflow holds while enable set.
// RQ8: break wake only available in asynchronous mode, never in synchronous mode.
// RQ9: wake enable suppresses normal reception; block idles watching the line.
// RQ10: a falling receive-line transition is the wake event.
// RQ11: wake sets receive flag, clocked when running, asynchronous when asleep.
// RQ12: rising edge ending the break clears wake enable; then idle.
// RQ13: sleep stops all transceiver clocks so nothing is received.
// RQ14: nonzero character: low time to first rising edge is the wake event.
// RQ15: remote sends all-zero wake character of ten or more bit times.
// RQ16: remote leaves break and idle time long enough for oscillator start.
// RQ17: software checks receiver idle status before setting wake enable.
// RQ18: wake falling edge captured by clock-independent logic while clocks stop.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "uaw_cfg.svh"

module uaw_autobaud_wake #(
  parameter int CNT_WIDTH = `UAW_CNT_WIDTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire uaw_pkg::uaw_bus_req_t busReq,
  output logic [7:0] rdData,
  input wire logic serialReceiveLine,
  input wire logic baudTick,
  input wire uaw_pkg::uaw_char_in_t charIn,
  output logic receiveInterruptFlag,
  output logic charReceiveEnable,
  output logic transceiverClockRun,
  output logic wakeAsync,
  output logic [CNT_WIDTH-1:0] baudDivisor
);
  import uaw_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rstMeta_q;
  logic rstSync_q;
  logic rstN;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  assign rstN = rstSync_q;

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic autoBaudDetectEnable_q;
  logic breakWakeEnable_q;
  logic syncMode_q;
  logic sleepRequest_q;
  logic rxFlag_q;
  logic baudCountOverflowFlag_q;
  logic [7:0] receiveData_q;
  logic [CNT_WIDTH-1:0] divisor_q;
  logic [CNT_WIDTH-1:0] count_q;
  logic [2:0] edgeCount_q;
  uaw_abd_state_t abdState_q;
  logic [7:0] rdData_q;
  logic rxMeta_q;
  logic rxSync_q;
  logic rxPrev_q;
  logic wakeLatch_q;
  logic wkMeta_q;
  logic wkSync_q;
  logic wkPrev_q;
  logic wakeSeen_q;
  logic rxRise;
  logic wakeEvent;
  logic abdDone;
  logic wakeEnd;
  logic countWrap;
  logic receiverIdleStatus;
  logic wrCtrl;
  logic wrStat;
  logic wrDivl;
  logic wrDivh;
  logic rdRxData;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wrCtrl = busReq.wr && hit(busReq.addr, `UAW_OFS_CTRL);
  assign wrStat = busReq.wr && hit(busReq.addr, `UAW_OFS_STAT);
  assign wrDivl = busReq.wr && hit(busReq.addr, `UAW_OFS_DIVL);
  assign wrDivh = busReq.wr && hit(busReq.addr, `UAW_OFS_DIVH);
  assign rdRxData = busReq.rd && hit(busReq.addr, `UAW_OFS_RXDATA);

  // ------------------------------------------------------------
  // receive line synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
      rxPrev_q <= 1'b1;
    end else begin
      rxMeta_q <= serialReceiveLine;
      rxSync_q <= rxMeta_q;
      rxPrev_q <= rxSync_q;
    end
  end

  assign rxRise = rxSync_q && !rxPrev_q;

  // ------------------------------------------------------------
  // clock-free wake capture
  // ------------------------------------------------------------
  // RQ18: edge capture
  // the line itself clocks this flop, so the event is held with sys_clk stopped
  always_ff @(negedge serialReceiveLine or negedge breakWakeEnable_q) begin
    if (!breakWakeEnable_q) begin
      wakeLatch_q <= 1'b0;
    end else begin
      // RQ10: falling edge wakes
      wakeLatch_q <= 1'b1;
    end
  end

  // RQ11: asynchronous when asleep
  assign wakeAsync = wakeLatch_q;

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wkMeta_q <= 1'b0;
      wkSync_q <= 1'b0;
      wkPrev_q <= 1'b0;
    end else begin
      wkMeta_q <= wakeLatch_q;
      wkSync_q <= wkMeta_q;
      wkPrev_q <= wkSync_q;
    end
  end

  assign wakeEvent = wkSync_q && !wkPrev_q;

  // wake seen, waiting for the end of the break
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      wakeSeen_q <= 1'b0;
    end else if (!breakWakeEnable_q) begin
      wakeSeen_q <= 1'b0;
    end else if (wakeEvent) begin
      wakeSeen_q <= 1'b1;
    end
  end

  // RQ12: break end clears
  // RQ14: first rising edge ends
  assign wakeEnd = breakWakeEnable_q && wakeSeen_q && rxRise;

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      syncMode_q <= 1'b0;
      sleepRequest_q <= 1'b0;
    end else if (wrCtrl) begin
      syncMode_q <= busReq.wdata[`UAW_CTRL_SYNC];
      sleepRequest_q <= busReq.wdata[`UAW_CTRL_SLEEP];
    end
  end

  // RQ4: hardware clears enable
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      autoBaudDetectEnable_q <= 1'b0;
    end else if (abdDone) begin
      autoBaudDetectEnable_q <= 1'b0;
    end else if (wrCtrl) begin
      autoBaudDetectEnable_q <= busReq.wdata[`UAW_CTRL_ABD];
    end
  end

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      breakWakeEnable_q <= 1'b0;
    end else if (wakeEnd || syncMode_q) begin
      // RQ8: async mode only
      breakWakeEnable_q <= 1'b0;
    end else if (wrCtrl) begin
      breakWakeEnable_q <= busReq.wdata[`UAW_CTRL_WAKE] && !busReq.wdata[`UAW_CTRL_SYNC];
    end
  end

  // RQ9: reception suppressed
  // RQ13: sleep halts clocks
  assign charReceiveEnable = !breakWakeEnable_q && !autoBaudDetectEnable_q && !sleepRequest_q;
  assign transceiverClockRun = !sleepRequest_q;

  // ------------------------------------------------------------
  // auto baud measurement
  // ------------------------------------------------------------
  // RQ2: sixteen bit counter
  assign countWrap = baudTick && (count_q == {CNT_WIDTH{1'b1}});
  assign abdDone = (abdState_q == ABD_MEASURE) && rxRise && autoBaudDetectEnable_q
                   && (edgeCount_q == `UAW_LAST_EDGE - 3'h1);

  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      abdState_q <= ABD_IDLE;
      count_q <= '0;
      edgeCount_q <= 3'h0;
    end else if (!autoBaudDetectEnable_q) begin
      abdState_q <= ABD_IDLE;
    end else begin
      unique case (abdState_q)
        ABD_IDLE: begin
          abdState_q <= ABD_WAIT_FIRST;
        end
        ABD_WAIT_FIRST: begin
          if (rxRise) begin
            abdState_q <= ABD_MEASURE;
            count_q <= '0;
            edgeCount_q <= 3'h1;
          end
        end
        ABD_MEASURE: begin
          // RQ3: count through overflow
          if (baudTick) begin
            count_q <= count_q + 1'b1;
          end
          if (abdDone) begin
            abdState_q <= ABD_IDLE;
          end else if (rxRise) begin
            edgeCount_q <= edgeCount_q + 3'h1;
          end
        end
        default: begin
          abdState_q <= ABD_IDLE;
        end
      endcase
    end
  end

  // overflow flag
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      baudCountOverflowFlag_q <= 1'b0;
    end else if (abdState_q == ABD_MEASURE && autoBaudDetectEnable_q && countWrap) begin
      // RQ1: wrap sets overflow
      baudCountOverflowFlag_q <= 1'b1;
    end else if (wrStat && !busReq.wdata[`UAW_STAT_OVF] && !autoBaudDetectEnable_q) begin
      // RQ6: direct write clears
      // RQ7: held while enabled
      baudCountOverflowFlag_q <= 1'b0;
    end
  end

  // divisor pair, loaded by measurement or by software
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      divisor_q <= `UAW_RST_DIV;
    end else if (abdDone) begin
      divisor_q <= count_q;
    end else if (wrDivl) begin
      divisor_q[7:0] <= busReq.wdata;
    end else if (wrDivh) begin
      divisor_q[CNT_WIDTH-1:8] <= busReq.wdata[CNT_WIDTH-9:0];
    end
  end

  assign baudDivisor = divisor_q;

  // ------------------------------------------------------------
  // receive data and receive flag
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      receiveData_q <= `UAW_RST_DATA;
    end else if (charIn.done && charReceiveEnable) begin
      receiveData_q <= charIn.data;
    end
  end

  // set wins over the read clear
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rxFlag_q <= 1'b0;
    end else if (abdDone) begin
      // RQ4: completion sets flag
      rxFlag_q <= 1'b1;
    end else if (wakeEvent && breakWakeEnable_q) begin
      // RQ11: clocked wake flag
      rxFlag_q <= 1'b1;
    end else if (charIn.done && charReceiveEnable) begin
      rxFlag_q <= 1'b1;
    end else if (rdRxData) begin
      // RQ5: read clears flag
      rxFlag_q <= 1'b0;
    end
  end

  assign receiveInterruptFlag = rxFlag_q;

  // RQ17: idle status for software
  assign receiverIdleStatus = !charIn.busy && (abdState_q != ABD_MEASURE) && rxSync_q;

  // ------------------------------------------------------------
  // register read port
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      rdData_q <= 8'h00;
    end else if (busReq.rd) begin
      unique case (busReq.addr)
        `UAW_OFS_CTRL: begin
          rdData_q <= {4'h0, sleepRequest_q, syncMode_q, breakWakeEnable_q,
                       autoBaudDetectEnable_q};
        end
        `UAW_OFS_STAT: begin
          rdData_q <= {5'h00, receiverIdleStatus, baudCountOverflowFlag_q, rxFlag_q};
        end
        `UAW_OFS_DIVL: begin
          rdData_q <= divisor_q[7:0];
        end
        `UAW_OFS_DIVH: begin
          rdData_q <= divisor_q[CNT_WIDTH-1:CNT_WIDTH-8];
        end
        `UAW_OFS_RXDATA: begin
          rdData_q <= receiveData_q;
        end
        default: begin
          rdData_q <= 8'h00;
        end
      endcase
    end else begin
      rdData_q <= 8'h00;
    end
  end

  assign rdData = rdData_q;

endmodule
`default_nettype wire

/* verification/uaw_checker_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uaw_cfg.svh"
module uaw_checker #(
  parameter int CNT_WIDTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire uaw_pkg::uaw_bus_req_t busReq,
  input wire uaw_pkg::uaw_char_in_t charIn,
  input wire logic [7:0] rdData,
  input wire logic serialReceiveLine,
  input wire logic receiveInterruptFlag,
  input wire logic charReceiveEnable,
  input wire logic transceiverClockRun,
  input wire logic wakeAsync,
  input wire logic [CNT_WIDTH-1:0] baudDivisor
);
  import uaw_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  read_clear_a: assert property (
    busReq.rd && busReq.addr == `UAW_OFS_RXDATA && !charIn.done |=> !receiveInterruptFlag)
    else $error("flag kept after data read");
  wake_fall_a: assert property (
    $rose(wakeAsync) |-> !serialReceiveLine) else $error("wake without low line");
  wake_flag_a: assert property (
    $rose(wakeAsync) |-> ##[0:4] receiveInterruptFlag) else $error("wake flag late");
  wake_quiet_a: assert property (
    wakeAsync |-> !charReceiveEnable) else $error("receiver on during wake");
  wake_end_a: assert property (
    wakeAsync && $rose(serialReceiveLine) |-> ##[1:5] !wakeAsync)
    else $error("wake kept after break end");
  sleep_clock_a: assert property (
    busReq.wr && busReq.addr == `UAW_OFS_CTRL
    |=> transceiverClockRun == !$past(busReq.wdata[`UAW_CTRL_SLEEP]))
    else $error("clock run wrong");
  div_low_a: assert property (
    busReq.wr && busReq.addr == `UAW_OFS_DIVL |=> baudDivisor[7:0] == $past(busReq.wdata))
    else $error("divisor low wrong");
  div_hold_a: assert property (
    $changed(baudDivisor) |-> $past(busReq.wr) || $rose(receiveInterruptFlag))
    else $error("divisor moved alone");
endmodule
bind uaw_autobaud_wake uaw_checker #(.CNT_WIDTH(CNT_WIDTH)) uaw_checker_inst (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .busReq(busReq),
  .charIn(charIn),
  .rdData(rdData),
  .serialReceiveLine(serialReceiveLine),
  .receiveInterruptFlag(receiveInterruptFlag),
  .charReceiveEnable(charReceiveEnable),
  .transceiverClockRun(transceiverClockRun),
  .wakeAsync(wakeAsync),
  .baudDivisor(baudDivisor)
);
`default_nettype wire

/* verification/uaw_remote_node.sv */
`timescale 1ns/1ps
`default_nettype none
module uaw_remote_node #(
  parameter int BIT_NS = 40
) (
  output logic line
);
  initial line = 1'b1;
  task automatic send_break(input int bits);
    // start off the clock edge so the pin never races the sampling flop
    #1;
    line = 1'b0;
    #(bits * BIT_NS);
    line = 1'b1;
    #(4 * BIT_NS);
  endtask
  // five rising edges, first gap stretchable
  task automatic send_sync(input int hi1, input int bt);
    #1;
    for (int i = 0; i < 5; i++) begin
      line = 1'b0;
      #(bt);
      line = 1'b1;
      #(i == 0 ? hi1 : bt);
    end
  endtask
endmodule
`default_nettype wire

/* verification/test_uaw_autobaud_wake.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uaw_cfg.svh"
module test_uaw_autobaud_wake;
  import uaw_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic baudTick = 1'b0;
  logic tickAll = 1'b0;
  logic serialReceiveLine;
  logic receiveInterruptFlag;
  logic charReceiveEnable;
  logic transceiverClockRun;
  logic wakeAsync;
  logic [7:0] rdData;
  logic [7:0] d;
  logic [15:0] baudDivisor;
  logic [15:0] v;
  uaw_bus_req_t busReq = '0;
  uaw_char_in_t charIn = '0;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int seed = 32'h24fa;
  int bt;
  always #2 sys_clk = ~sys_clk;
  uaw_autobaud_wake uaw_autobaud_wake_inst (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .busReq(busReq),
    .rdData(rdData),
    .serialReceiveLine(serialReceiveLine),
    .baudTick(baudTick),
    .charIn(charIn),
    .receiveInterruptFlag(receiveInterruptFlag),
    .charReceiveEnable(charReceiveEnable),
    .transceiverClockRun(transceiverClockRun),
    .wakeAsync(wakeAsync),
    .baudDivisor(baudDivisor)
  );
  uaw_remote_node uaw_remote_node_inst (
    .line(serialReceiveLine)
  );
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    baudTick <= tickAll | 1'($random(seed));
    cyc++;
    if (cyc == 95000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_near(input logic [15:0] g, input logic [15:0] e, input int tol);
    total_checks++;
    if ((g + tol >= e && g <= e + tol) !== 1'b1) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // expected divisor: clock periods from first to fifth rise, kept to 16 bits
  function automatic logic [15:0] exp_div(input int hi1, input int bitNs);
    exp_div = 16'((hi1 + 7 * bitNs) / 4);
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge sys_clk);
    busReq <= '{a, w, 1'b1, 1'b0};
    @(posedge sys_clk);
    busReq.wr <= 1'b0;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    busReq.rd <= 1'b0;
    #1 d = rdData;
    chk(d & m, e);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk_rd(`UAW_OFS_CTRL, 8'hff, 8'h00);
    chk_rd(8'h14, 8'hff, 8'h00);
    v = 16'($random(seed));
    wr(`UAW_OFS_DIVL, v[7:0]);
    wr(`UAW_OFS_DIVH, v[15:8]);
    chk_rd(`UAW_OFS_DIVH, 8'hff, v[15:8]);
    chk(baudDivisor, v);
    @(posedge sys_clk);
    charIn <= '{v[7:0], 1'b1, 1'b0};
    @(posedge sys_clk);
    charIn.done <= 1'b0;
    chk_rd(`UAW_OFS_RXDATA, 8'hff, v[7:0]);
    chk(receiveInterruptFlag, 1'b0);
    tickAll = 1'b1;
    bt = 40 + 4 * ($random(seed) & 255);
    wr(`UAW_OFS_CTRL, 8'h01);
    uaw_remote_node_inst.send_sync(bt, bt);
    chk(receiveInterruptFlag, 1'b1);
    chk_near(baudDivisor, exp_div(bt, bt), 3);
    chk_rd(`UAW_OFS_RXDATA, 8'hff, v[7:0]);
    wr(`UAW_OFS_CTRL, 8'h01);
    wr(`UAW_OFS_CTRL, 8'h00);
    wr(`UAW_OFS_STAT, 8'h00);
    uaw_remote_node_inst.send_sync(bt, bt);
    chk(receiveInterruptFlag, 1'b0);
    wr(`UAW_OFS_CTRL, 8'h01);
    fork
      uaw_remote_node_inst.send_sync(264000, 40);
      begin
        repeat (65800) @(posedge sys_clk);
        chk_rd(`UAW_OFS_STAT, 8'h02, 8'h02);
        wr(`UAW_OFS_STAT, 8'h00);
        chk_rd(`UAW_OFS_STAT, 8'h02, 8'h02);
      end
    join
    chk(receiveInterruptFlag, 1'b1);
    chk_rd(`UAW_OFS_CTRL, 8'h01, 8'h00);
    chk_near(baudDivisor, exp_div(264000, 40), 3);
    chk_rd(`UAW_OFS_STAT, 8'h02, 8'h02);
    wr(`UAW_OFS_STAT, 8'h00);
    chk_rd(`UAW_OFS_STAT, 8'h02, 8'h00);
    chk_rd(`UAW_OFS_RXDATA, 8'hff, v[7:0]);
    tickAll = 1'b0;
    @(posedge sys_clk);
    charIn.busy <= 1'b1;
    chk_rd(`UAW_OFS_STAT, 8'h04, 8'h00);
    charIn.busy <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      chk_rd(`UAW_OFS_STAT, 8'h04, 8'h04);
      wr(`UAW_OFS_CTRL, k == 1 ? 8'h0a : 8'h02);
      charIn <= '{8'h5a, 1'b1, 1'b0};
      @(posedge sys_clk);
      charIn.done <= 1'b0;
      @(posedge sys_clk);
      #1 chk(charReceiveEnable, 1'b0);
      chk(receiveInterruptFlag, 1'b0);
      chk(transceiverClockRun, k != 1);
      fork
        uaw_remote_node_inst.send_break(k == 2 ? 1 : 13 - 3 * k);
        begin
          repeat (5) @(posedge sys_clk);
          #1 chk(wakeAsync, 1'b1);
          chk(receiveInterruptFlag, 1'b1);
        end
      join
      chk(receiveInterruptFlag, 1'b1);
      chk(wakeAsync, 1'b0);
      chk_rd(`UAW_OFS_CTRL, 8'h02, 8'h00);
      chk_rd(`UAW_OFS_RXDATA, 8'hff, v[7:0]);
      chk(receiveInterruptFlag, 1'b0);
      wr(`UAW_OFS_CTRL, 8'h00);
    end
    wr(`UAW_OFS_CTRL, 8'h06);
    chk_rd(`UAW_OFS_CTRL, 8'h02, 8'h00);
    uaw_remote_node_inst.send_break(13);
    chk(receiveInterruptFlag, 1'b0);
    chk(wakeAsync, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
